// ===== pkg/rimx_pkg.sv
`default_nettype none
package rimx_pkg;
	////////////////////////////////////////////////////////////////////////////
	// register offsets
	localparam logic [7:0] RIMX_OFS_PENDING = 8'h1B;
	localparam logic [7:0] RIMX_OFS_MEAS_PENDING = 8'h1C;
	localparam logic [7:0] RIMX_OFS_LIVE = 8'h1D;
	localparam logic [7:0] RIMX_OFS_TOP_MASK = 8'h20;
	localparam logic [7:0] RIMX_OFS_CONV_MASK = 8'h22;
	localparam logic [7:0] RIMX_OFS_REG_MASK = 8'h23;
	localparam logic [7:0] RIMX_OFS_SELECT = 8'h24;
	localparam logic [7:0] RIMX_OFS_CUR_HIGH = 8'h25;
	localparam logic [7:0] RIMX_OFS_CUR_LOW = 8'h26;
	////////////////////////////////////////////////////////////////////////////
	// field positions inside both mask registers, then the top mask, select and result bits
	localparam int RIMX_BIT_OC0 = 0;
	localparam int RIMX_BIT_PG_VALID0 = 2;
	localparam int RIMX_BIT_PG_INVALID0 = 3;
	localparam int RIMX_BIT_OC1 = 4;
	localparam int RIMX_BIT_PG_VALID1 = 6;
	localparam int RIMX_BIT_PG_INVALID1 = 7;
	localparam int RIMX_BIT_MEAS_MASK = 0;
	localparam int RIMX_BIT_SELECT = 0;
	localparam int RIMX_BIT_CUR_MSB = 8;
	// reserved bits 5 and 1 of the mask registers read as zero
	localparam logic [7:0] RIMX_MASK_RESERVED = 8'h22;
	////////////////////////////////////////////////////////////////////////////
	// reset values and limits
	localparam logic [7:0] RIMX_SELECT_RST = 8'h00;
	localparam logic [8:0] RIMX_CUR_RST = 9'h000;
	localparam logic [8:0] RIMX_CUR_MAX = 9'h1FF;
	localparam logic [6:0] RIMX_DEV_ADDR_DEFAULT = 7'h60; // serial address, value arbitrary
	////////////////////////////////////////////////////////////////////////////
	// live detector outputs, one pair per rail
	typedef struct packed {
		logic reg1_overcurrent_live;
		logic reg1_pg_live;
		logic reg0_overcurrent_live;
		logic reg0_pg_live;
		logic conv1_overcurrent_live;
		logic conv1_pg_live;
		logic conv0_overcurrent_live;
		logic conv0_pg_live;
	} rimx_live_t;
	// converter phase configuration
	typedef struct packed {
		logic dual_phase;
		logic master_is_conv1;
	} rimx_cfg_t;
	// current sensing front end answer, 20 mA per count
	typedef struct packed {
		logic done;
		logic [8:0] conv1_cur;
		logic [8:0] conv0_cur;
	} rimx_adc_t;
	// nonvolatile mask defaults
	typedef struct packed {
		logic [7:0] conv_mask;
		logic [7:0] reg_mask;
		logic measure_ready_mask;
	} rimx_nv_t;
	// serial register port states
	typedef enum logic [3:0] {
		RIMX_IDLE, RIMX_DEV, RIMX_DEV_ACK, RIMX_REG, RIMX_REG_ACK,
		RIMX_WDATA, RIMX_WDATA_ACK, RIMX_RDATA, RIMX_RD_ACK, RIMX_RD_NEXT
	} rimx_i2c_st_t;
endpackage
`default_nettype wire

// ===== rtl/rimx_chan_irq.sv
`timescale 1ns/1ns
`default_nettype none
module rimx_chan_irq (
	input wire logic mclk, // system clock
	input wire logic rst, // synchronous reset, high
	input wire logic pg_live, // live power-good level
	input wire logic oc_live, // live current-limit level
	input wire logic pg_valid_mask, // 1 blocks power-good valid events
	input wire logic pg_invalid_mask, // 1 blocks power-good invalid events
	input wire logic oc_mask, // 1 blocks current-limit events
	input wire logic clr_pg, // clear power-good pending
	input wire logic clr_oc, // clear current-limit pending
	output logic pg_irq, // power-good pending
	output logic oc_irq // current-limit pending
);
	logic pg_prev;
	logic oc_prev;
	logic pg_event;
	logic oc_event;

	////////////////////////////////////////////////////////////////////////////
	// edge tracking; seeded from the level so a rail already good is no event
	always_ff @(posedge mclk) begin
		if (rst) begin
			pg_prev <= pg_live;
			oc_prev <= oc_live;
		end else begin
			pg_prev <= pg_live;
			oc_prev <= oc_live;
		end
	end

	// masks gate only the events, the live levels pass untouched
	assign pg_event = (pg_live & ~pg_prev & ~pg_valid_mask) |
		(~pg_live & pg_prev & ~pg_invalid_mask);
	assign oc_event = oc_live & ~oc_prev & ~oc_mask;

	// sticky pending; a new event beats a clear in the same cycle
	always_ff @(posedge mclk) begin
		if (rst) begin
			pg_irq <= 1'b0;
			oc_irq <= 1'b0;
		end else begin
			pg_irq <= pg_event | (pg_irq & ~clr_pg);
			oc_irq <= oc_event | (oc_irq & ~clr_oc);
		end
	end
endmodule // rimx_chan_irq
`default_nettype wire

// ===== rtl/rimx_meas.sv
`timescale 1ns/1ns
`default_nettype none
module rimx_meas (
	input wire logic mclk, // system clock
	input wire logic rst, // synchronous reset, high
	input wire logic start, // one-cycle start from a select write
	input wire logic sel_conv1, // 0 measures converter 0, 1 converter 1
	input wire rimx_pkg::rimx_cfg_t cfg, // phase configuration
	input wire rimx_pkg::rimx_adc_t adc, // front end answer
	output logic adc_req, // one-cycle request to the front end
	output logic busy, // measurement running
	output logic ready, // one-cycle result strobe
	output logic [8:0] result // result, 20 mA per count
);
	import rimx_pkg::*;

	logic which;

	// sum of both phases, held at full scale instead of wrapping
	function automatic logic [8:0] sat_sum(input logic [8:0] a, input logic [8:0] b);
		logic [9:0] s;
		s = {1'b0, a} + {1'b0, b};
		return s[9] ? RIMX_CUR_MAX : s[8:0];
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// a fresh start always wins, even over a completing measurement
	always_ff @(posedge mclk) begin
		if (rst) begin
			adc_req <= 1'b0;
			busy <= 1'b0;
			ready <= 1'b0;
			which <= 1'b0;
			result <= RIMX_CUR_RST;
		end else begin
			adc_req <= start;
			ready <= 1'b0;
			if (start) begin
				busy <= 1'b1;
				which <= sel_conv1;
			end else if (busy && adc.done) begin
				busy <= 1'b0;
				ready <= 1'b1;
				if (cfg.dual_phase && (which == cfg.master_is_conv1))
					result <= sat_sum(adc.conv0_cur, adc.conv1_cur); // [RULE16]
				else
					result <= which ? adc.conv1_cur : adc.conv0_cur; // [RULE17]
			end
		end
	end
endmodule // rimx_meas
`default_nettype wire

// ===== rtl/rimx_top.sv
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// [RULE1] conv mask bit 6 blocks conv1 good-rise events
// [RULE2] conv mask bit 4 blocks conv1 overcurrent events
// [RULE3] conv mask bit 3 blocks conv0 good-fall events
// [RULE4] conv mask bit 2 blocks conv0 good-rise events
// [RULE5] conv mask bit 0 blocks conv0 overcurrent events
// [RULE6] masks never alter live status bits
// [RULE7] mask bits 5 and 1 read zero
// [RULE8] reg mask bit 7 blocks reg1 good-fall events
// [RULE9] reg mask bit 6 blocks reg1 good-rise events
// [RULE10] reg mask bit 4 blocks reg1 overcurrent events
// [RULE11] reg mask bit 3 blocks reg0 good-fall events
// [RULE12] reg mask bit 2 blocks reg0 good-rise events
// [RULE13] reg mask bit 0 blocks reg0 overcurrent events
// [RULE14] select bit 0 picks converter; resets zero
// [RULE15] each select write starts a measurement
// [RULE16] master selected: report master plus slave current
// [RULE17] slave selected: report its own current
// [RULE18] finished measurement raises maskable ready interrupt
// [RULE19] nine-bit result split high bit, low byte
// [RULE20] mask defaults load from nonvolatile store
// [RULE21] interrupt pin active while unmasked pending remains
module rimx_top #(
	parameter logic [6:0] DEV_ADDR = rimx_pkg::RIMX_DEV_ADDR_DEFAULT // serial address
) (
	input wire logic mclk, // system clock, 10 MHz
	input wire logic rst, // synchronous reset, high
	input wire logic scl, // serial clock level
	input wire logic sda_in, // serial data level seen on the wire
	output logic sda_out, // serial data drive value, always low
	output logic sda_oe, // high while pulling data low
	input wire rimx_pkg::rimx_live_t live, // live detector levels
	input wire rimx_pkg::rimx_cfg_t cfg, // converter phase setup
	input wire rimx_pkg::rimx_adc_t adc, // current front end answer
	input wire rimx_pkg::rimx_nv_t nv, // nonvolatile mask defaults
	output logic meas_req, // one-cycle measurement request
	output logic irq_n // interrupt, active low
);
	import rimx_pkg::*;

	// serial port state and line history
	rimx_i2c_st_t st;
	logic scl_q;
	logic sda_q;
	logic scl_rise;
	logic scl_fall;
	logic start_cond;
	logic stop_cond;
	logic [2:0] cnt;
	logic [7:0] shreg;
	logic [7:0] txb;
	logic [7:0] ptr;
	logic [7:0] rd_byte;
	logic wr_stb;
	// register file and measurement hand-off
	logic [7:0] conv_mask;
	logic [7:0] reg_mask;
	logic measure_ready_mask;
	logic [7:0] select;
	logic meas_go;
	logic meas_ready;
	logic [8:0] meas_result;
	logic measure_ready_irq;
	logic [7:0] pend;
	logic [7:0] clr;
	logic [7:0] live_byte;
	logic [3:0] pgv_mask;
	logic [3:0] pgi_mask;
	logic [3:0] oc_mask;

	// write strobe aimed at one offset; strobe and pointer are arguments so
	// continuous assignments that call this see every input change
	function automatic logic wr_hit(input logic stb, input logic [7:0] p,
		input logic [7:0] ofs);
		return stb && (p == ofs);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// serial line sampling; lines idle high so reset to one
	always_ff @(posedge mclk) begin
		if (rst) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl;
			sda_q <= sda_in;
		end
	end

	// bus events; data edges with clock high are start and stop
	assign scl_rise = scl & ~scl_q;
	assign scl_fall = ~scl & scl_q;
	assign start_cond = scl & scl_q & sda_q & ~sda_in;
	assign stop_cond = scl & scl_q & ~sda_q & sda_in;

	////////////////////////////////////////////////////////////////////////////
	// byte engine of the serial port; acks are driven on falling clock edges
	// so data never changes while the clock is high
	always_ff @(posedge mclk) begin
		if (rst) begin
			st <= RIMX_IDLE;
			cnt <= 3'h0;
			shreg <= 8'h00;
			txb <= 8'h00;
			ptr <= 8'h00;
			sda_out <= 1'b0;
			sda_oe <= 1'b0;
			wr_stb <= 1'b0;
		end else begin
			sda_out <= 1'b0;
			wr_stb <= 1'b0;
			if (start_cond) begin
				// a repeated start also lands here
				st <= RIMX_DEV;
				cnt <= 3'h0;
				sda_oe <= 1'b0;
			end else if (stop_cond) begin
				st <= RIMX_IDLE;
				sda_oe <= 1'b0;
			end else begin
				case (st)
					// deaf until a start, even to our own address
					RIMX_IDLE: begin
						sda_oe <= 1'b0;
					end
					RIMX_DEV, RIMX_REG, RIMX_WDATA: begin
						// shift in msb first, eighth bit moves to the ack phase
						if (scl_rise) begin
							shreg <= {shreg[6:0], sda_in};
							cnt <= cnt + 3'h1;
							if (cnt == 3'h7) begin
								if (st == RIMX_DEV)
									st <= RIMX_DEV_ACK;
								else if (st == RIMX_REG)
									st <= RIMX_REG_ACK;
								else
									st <= RIMX_WDATA_ACK;
							end
						end
					end
					// first fall drives the ack, second fall ends it
					RIMX_DEV_ACK: begin
						if (scl_fall) begin
							if (!sda_oe) begin
								// foreign address: stay off the bus until next start
								if (shreg[7:1] == DEV_ADDR)
									sda_oe <= 1'b1;
								else
									st <= RIMX_IDLE;
							end else if (shreg[0]) begin
								// read: first byte comes from the current pointer
								st <= RIMX_RDATA;
								cnt <= 3'h0;
								sda_oe <= ~rd_byte[7];
								txb <= {rd_byte[6:0], 1'b0};
							end else begin
								st <= RIMX_REG;
								sda_oe <= 1'b0;
							end
						end
					end
					// pointer loads only once the ack has ended
					RIMX_REG_ACK: begin
						if (scl_fall) begin
							if (!sda_oe) begin
								sda_oe <= 1'b1;
							end else begin
								sda_oe <= 1'b0;
								ptr <= shreg;
								st <= RIMX_WDATA;
							end
						end
					end
					RIMX_WDATA_ACK: begin
						// commit during the ack, advance once it ends
						if (scl_fall) begin
							if (!sda_oe) begin
								sda_oe <= 1'b1;
								wr_stb <= 1'b1;
							end else begin
								sda_oe <= 1'b0;
								ptr <= ptr + 8'h01;
								st <= RIMX_WDATA;
							end
						end
					end
					// next bit goes out after each fall, never while clock high
					RIMX_RDATA: begin
						if (scl_rise) begin
							cnt <= cnt + 3'h1;
							if (cnt == 3'h7)
								st <= RIMX_RD_ACK;
						end else if (scl_fall) begin
							sda_oe <= ~txb[7];
							txb <= {txb[6:0], 1'b0};
						end
					end
					RIMX_RD_ACK: begin
						// release for the master's ack, a nack ends the burst
						if (scl_fall) begin
							sda_oe <= 1'b0;
						end else if (scl_rise) begin
							ptr <= ptr + 8'h01;
							st <= sda_in ? RIMX_IDLE : RIMX_RD_NEXT;
						end
					end
					// next byte starts at the fall after the master's ack
					RIMX_RD_NEXT: begin
						if (scl_fall) begin
							st <= RIMX_RDATA;
							cnt <= 3'h0;
							sda_oe <= ~rd_byte[7];
							txb <= {rd_byte[6:0], 1'b0};
						end
					end
					default: begin
						st <= RIMX_IDLE;
						sda_oe <= 1'b0;
					end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// mask registers; defaults come from the nonvolatile store, not constants
	always_ff @(posedge mclk) begin
		if (rst) begin
			conv_mask <= nv.conv_mask & ~RIMX_MASK_RESERVED; // [RULE20] [RULE7]
			reg_mask <= nv.reg_mask & ~RIMX_MASK_RESERVED; // [RULE20] [RULE7]
			measure_ready_mask <= nv.measure_ready_mask; // [RULE20]
		end else if (wr_stb) begin
			if (ptr == RIMX_OFS_CONV_MASK)
				conv_mask <= shreg & ~RIMX_MASK_RESERVED; // [RULE7]
			if (ptr == RIMX_OFS_REG_MASK)
				reg_mask <= shreg & ~RIMX_MASK_RESERVED; // [RULE7]
			// only bit 0 of the top mask byte is kept, the rest reads zero
			if (ptr == RIMX_OFS_TOP_MASK)
				measure_ready_mask <= shreg[RIMX_BIT_MEAS_MASK];
		end
	end

	// measurement select; every write restarts, even with the same value
	always_ff @(posedge mclk) begin
		if (rst) begin
			select <= RIMX_SELECT_RST; // [RULE14]
			meas_go <= 1'b0;
		end else begin
			meas_go <= wr_hit(wr_stb, ptr, RIMX_OFS_SELECT); // [RULE15]
			if (wr_hit(wr_stb, ptr, RIMX_OFS_SELECT))
				select <= shreg;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// per-rail mask vectors, index 0/1 converters, 2/3 regulators
	assign pgv_mask[0] = conv_mask[RIMX_BIT_PG_VALID0]; // [RULE4]
	assign pgi_mask[0] = conv_mask[RIMX_BIT_PG_INVALID0]; // [RULE3]
	assign oc_mask[0] = conv_mask[RIMX_BIT_OC0]; // [RULE5]
	assign pgv_mask[1] = conv_mask[RIMX_BIT_PG_VALID1]; // [RULE1]
	assign pgi_mask[1] = conv_mask[RIMX_BIT_PG_INVALID1];
	assign oc_mask[1] = conv_mask[RIMX_BIT_OC1]; // [RULE2]
	assign pgv_mask[2] = reg_mask[RIMX_BIT_PG_VALID0]; // [RULE12]
	assign pgi_mask[2] = reg_mask[RIMX_BIT_PG_INVALID0]; // [RULE11]
	assign oc_mask[2] = reg_mask[RIMX_BIT_OC0]; // [RULE13]
	assign pgv_mask[3] = reg_mask[RIMX_BIT_PG_VALID1]; // [RULE9]
	assign pgi_mask[3] = reg_mask[RIMX_BIT_PG_INVALID1]; // [RULE8]
	assign oc_mask[3] = reg_mask[RIMX_BIT_OC1]; // [RULE10]

	// live byte goes straight to the reader, masks never touch it
	assign live_byte = live; // [RULE6]
	// write one to clear the pending byte
	assign clr = wr_hit(wr_stb, ptr, RIMX_OFS_PENDING) ? shreg : 8'h00;

	// one event tracker per rail; pending byte shares the live byte layout
	for (genvar i = 0; i < 4; i++) begin : g_rail
		rimx_chan_irq u_chan (
			.mclk(mclk),
			.rst(rst),
			.pg_live(live_byte[2*i]),
			.oc_live(live_byte[2*i+1]),
			.pg_valid_mask(pgv_mask[i]),
			.pg_invalid_mask(pgi_mask[i]),
			.oc_mask(oc_mask[i]),
			.clr_pg(clr[2*i]),
			.clr_oc(clr[2*i+1]),
			.pg_irq(pend[2*i]),
			.oc_irq(pend[2*i+1])
		);
	end

	////////////////////////////////////////////////////////////////////////////
	// load current measurement
	rimx_meas u_meas (
		.mclk(mclk),
		.rst(rst),
		.start(meas_go), // [RULE15]
		.sel_conv1(select[RIMX_BIT_SELECT]), // [RULE14]
		.cfg(cfg),
		.adc(adc),
		.adc_req(meas_req),
		.busy(), // running state only matters inside the engine
		.ready(meas_ready),
		.result(meas_result)
	);

	// ready pending; the top-level mask stops it being raised at all
	always_ff @(posedge mclk) begin
		if (rst) begin
			measure_ready_irq <= 1'b0;
		end else begin
			measure_ready_irq <= (meas_ready & ~measure_ready_mask) | // [RULE18]
				(measure_ready_irq & ~(wr_hit(wr_stb, ptr, RIMX_OFS_MEAS_PENDING) &&
				shreg[RIMX_BIT_MEAS_MASK]));
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// interrupt pin; pending bits were gated by their masks when raised
	// so a later unmask never raises the pin for an old event
	always_ff @(posedge mclk) begin
		if (rst)
			irq_n <= 1'b1;
		else
			irq_n <= ~((|pend) | measure_ready_irq); // [RULE21]
	end

	// register read mux; unmapped offsets read zero
	// no shadow copy of the result: read high then low in one burst
	always_comb begin
		case (ptr)
			RIMX_OFS_PENDING: rd_byte = pend;
			RIMX_OFS_MEAS_PENDING: rd_byte = {7'h00, measure_ready_irq};
			RIMX_OFS_LIVE: rd_byte = live_byte; // [RULE6]
			RIMX_OFS_TOP_MASK: rd_byte = {7'h00, measure_ready_mask};
			RIMX_OFS_CONV_MASK: rd_byte = conv_mask;
			RIMX_OFS_REG_MASK: rd_byte = reg_mask;
			RIMX_OFS_SELECT: rd_byte = select;
			RIMX_OFS_CUR_HIGH: rd_byte = {7'h00, meas_result[RIMX_BIT_CUR_MSB]}; // [RULE19]
			RIMX_OFS_CUR_LOW: rd_byte = meas_result[7:0]; // [RULE19]
			default: rd_byte = 8'h00;
		endcase
	end
endmodule // rimx_top
`default_nettype wire

// ===== tb/rimx_chk.sv
`timescale 1ns/1ns
`default_nettype none
module rimx_chk (
	input wire logic mclk, // system clock
	input wire logic rst, // synchronous reset, high
	input wire logic scl, // serial clock level
	input wire logic sda_in, // resolved data wire
	input wire logic sda_out, // data drive value
	input wire logic sda_oe, // data pull enable
	input wire rimx_pkg::rimx_live_t live, // live detector levels
	input wire rimx_pkg::rimx_cfg_t cfg, // phase setup
	input wire rimx_pkg::rimx_adc_t adc, // front end answer
	input wire rimx_pkg::rimx_nv_t nv, // mask defaults
	input wire logic meas_req, // measurement request
	input wire logic irq_n // interrupt, active low
);
	import rimx_pkg::*;
	rimx_live_t live_q;
	logic scl_q;
	logic [2:0] cause_hist;
	logic [3:0] since_fall;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	// recent causes for a pin fall: a live edge or a finished measurement
	always_ff @(posedge mclk) begin
		live_q <= live;
		scl_q <= scl;
		cause_hist <= rst ? 3'h0 : {cause_hist[1:0], (live != live_q) || adc.done};
	end
	// cycles since the last clock fall, saturating so idle time never wraps
	always_ff @(posedge mclk) begin
		if (rst) since_fall <= 4'hF;
		else if (scl_q && !scl) since_fall <= 4'h0;
		else if (since_fall != 4'hF) since_fall <= since_fall + 4'h1;
	end
	////////////////////////////////////////////////////////////////////////////
	sequence s_req_quiet;
		!meas_req [*8];
	endsequence
	sequence s_idle_two;
		(irq_n && !sda_oe && !meas_req) [*2];
	endsequence
	AST_MEAS_PULSE: assert property (meas_req |=> s_req_quiet)
		else $error("measurement request too long or too close");
	AST_MEAS_AFTER_ACK: assert property ($rose(meas_req) |-> since_fall < 4'hA)
		else $error("measurement request without a serial write");
	AST_IRQ_CAUSE: assert property ($fell(irq_n) |-> cause_hist != 3'h0)
		else $error("interrupt raised without an event");
	AST_IRQ_RELEASE: assert property ($rose(irq_n) |-> since_fall < 4'hA)
		else $error("interrupt dropped without a clear access");
	AST_OE_RISE: assert property ($rose(sda_oe) |-> !scl)
		else $error("data pulled while clock high");
	AST_OE_STEADY: assert property (scl && $past(scl) |-> $stable(sda_oe))
		else $error("data drive changed while clock high");
	AST_SDA_LOW_ONLY: assert property (sda_out == 1'b0)
		else $error("data drive value not low");
	AST_RESET_QUIET: assert property ($fell(rst) |-> s_idle_two)
		else $error("outputs active right after reset");
	cover property (!irq_n ##1 irq_n);
endmodule // rimx_chk
bind rimx_top rimx_chk u_chk (.mclk(mclk), .rst(rst), .scl(scl), .sda_in(sda_in),
	.sda_out(sda_out), .sda_oe(sda_oe), .live(live), .cfg(cfg), .adc(adc), .nv(nv),
	.meas_req(meas_req), .irq_n(irq_n));
`default_nettype wire

// ===== tb/rimx_host.sv
`timescale 1ns/1ns
`default_nettype none
module rimx_host (
	input wire logic mclk, // system clock
	input wire logic sda, // resolved data wire
	output logic scl, // serial clock, high between frames
	output logic sda_oe // high while pulling data low
);
	// idle bus: clock high, data released
	initial begin
		scl = 1'b1;
		sda_oe = 1'b0;
	end
	// three cycles per phase, above the two-sample minimum
	task automatic hold();
		repeat (3) @(negedge mclk);
	endtask
	// also serves as repeated start, entered with clock low
	task automatic start();
		sda_oe = 1'b0;
		hold();
		scl = 1'b1;
		hold();
		sda_oe = 1'b1;
		hold();
		scl = 1'b0;
		hold();
	endtask
	task automatic stop();
		sda_oe = 1'b1;
		hold();
		scl = 1'b1;
		hold();
		sda_oe = 1'b0;
		hold();
	endtask
	// data only changes while the clock is low
	task automatic bit_io(input logic b, output logic s);
		sda_oe = !b;
		hold();
		scl = 1'b1;
		hold();
		s = sda;
		scl = 1'b0;
		hold();
	endtask
	task automatic put(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) bit_io(d[i], s);
		bit_io(1'b1, ack);
	endtask
	task automatic get(output logic [7:0] d, input logic last);
		logic s;
		for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
		bit_io(last, s);
	endtask
endmodule // rimx_host
`default_nettype wire

// ===== tb/rimx_top_bench.sv
`timescale 1ns/1ns
`default_nettype none
module rimx_top_bench;
	import rimx_pkg::*;
	logic mclk, rst, scl, host_oe, sda, sda_out, sda_oe, meas_req, irq_n, ack, lv;
	rimx_live_t live;
	rimx_cfg_t cfg;
	rimx_adc_t adc;
	rimx_nv_t nv;
	logic [7:0] rb [0:2];
	logic [7:0] ofs;
	int failures, total_checks, req_count, b, l;
	// pull-up: the wire is low while either side pulls
	assign sda = !(sda_oe || host_oe);
	rimx_top DUT (.mclk(mclk), .rst(rst), .scl(scl), .sda_in(sda), .sda_out(sda_out),
		.sda_oe(sda_oe), .live(live), .cfg(cfg), .adc(adc), .nv(nv), .meas_req(meas_req),
		.irq_n(irq_n));
	rimx_host host (.mclk(mclk), .sda(sda), .scl(scl), .sda_oe(host_oe));
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	// pulses counted so every select write can be matched to one request
	always @(posedge mclk) if (meas_req === 1'b1) req_count++;
	////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t: %s got %h want %h", $time, what, seen, exp);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic wr(input logic [7:0] o, input logic [7:0] d);
		host.start();
		host.put({RIMX_DEV_ADDR_DEFAULT, 1'b0}, ack);
		host.put(o, ack);
		host.put(d, ack);
		check(ack, 0, "write ack");
		host.stop();
	endtask
	// burst read; the pointer steps after every byte
	task automatic rd(input logic [7:0] o, input int n);
		host.start();
		host.put({RIMX_DEV_ADDR_DEFAULT, 1'b0}, ack);
		host.put(o, ack);
		host.start();
		host.put({RIMX_DEV_ADDR_DEFAULT, 1'b1}, ack);
		for (int i = 0; i < n; i++) host.get(rb[i], i == n - 1);
		host.stop();
	endtask
	// one measurement; front end currents are fixed at 0x0AB and 0x123
	task automatic meas(input logic [7:0] sel, input rimx_cfg_t cf, input logic m,
		input logic [8:0] e);
		int n;
		n = req_count;
		cfg = cf;
		wr(RIMX_OFS_TOP_MASK, {7'h00, m});
		wr(RIMX_OFS_SELECT, sel);
		check(16'(req_count - n), 1, "requests per write");
		adc.done = 1'b1;
		@(negedge mclk);
		adc.done = 1'b0;
		repeat (4) @(negedge mclk);
		check(irq_n, m, "ready pin");
		rd(RIMX_OFS_SELECT, 3);
		check(rb[0], sel, "select readback");
		check({rb[1], rb[2]}, {7'h00, e}, "result");
		rd(RIMX_OFS_MEAS_PENDING, 1);
		check(rb[0], {7'h00, !m}, "ready pending");
		wr(RIMX_OFS_MEAS_PENDING, 8'h01);
		check(irq_n, 1, "ready cleared");
	endtask
	////////////////////////////////////////////////////////////////////////////
	// a hang counts as a mismatch and still reaches the verdict
	initial begin
		#8000000;
		failures++;
		$display("CHECK FAILED at %0t: run limit reached", $time);
		finish_test();
	end
	initial begin
		rst = 1'b1;
		live = '0;
		cfg = '0;
		adc = '{done: 1'b0, conv1_cur: 9'h123, conv0_cur: 9'h0AB};
		nv = '{conv_mask: 8'hFF, reg_mask: 8'hFF, measure_ready_mask: 1'b0};
		repeat (3) @(negedge mclk);
		rst = 1'b0;
		rd(RIMX_OFS_CONV_MASK, 3);
		check({rb[0], rb[1]}, 16'hDDDD, "mask defaults");
		check(rb[2], 8'h00, "select reset");
		rd(RIMX_OFS_CUR_HIGH, 2);
		check({rb[0], rb[1]}, 16'h0000, "result reset");
		$display("test reset_values done");
		wr(RIMX_OFS_CONV_MASK, 8'h77);
		wr(RIMX_OFS_REG_MASK, 8'hEE);
		rd(RIMX_OFS_CONV_MASK, 2);
		check({rb[0], rb[1]}, 16'h55CC, "reserved mask bits");
		wr(RIMX_OFS_CONV_MASK, 8'hFF);
		wr(RIMX_OFS_REG_MASK, 8'hFF);
		$display("test mask_fields done");
		// every source: masked event first, then the same event unmasked
		for (int r = 0; r < 2; r++) for (int c = 0; c < 2; c++) for (int k = 0; k < 3; k++) begin
			ofs = r ? RIMX_OFS_REG_MASK : RIMX_OFS_CONV_MASK;
			b = 4 * c + ((k == 0) ? 0 : k + 1);
			l = 4 * r + 2 * c + ((k == 0) ? 1 : 0);
			lv = (k == 2);
			live[l] = lv;
			repeat (3) @(negedge mclk);
			live[l] = !lv;
			repeat (3) @(negedge mclk);
			check(irq_n, 1, "masked pin");
			rd(RIMX_OFS_PENDING, 3);
			check(rb[0], 8'h00, "masked pending");
			check(rb[2], live, "live masked");
			live[l] = lv;
			wr(ofs, 8'hFF ^ (8'h01 << b));
			live[l] = !lv;
			repeat (3) @(negedge mclk);
			check(irq_n, 0, "unmasked pin");
			rd(RIMX_OFS_PENDING, 3);
			check(rb[0], 8'h01 << l, "unmasked pending");
			check(rb[2], live, "live unmasked");
			live[l] = lv;
			wr(RIMX_OFS_PENDING, 8'h01 << l);
			check(irq_n, 1, "cleared pin");
			wr(ofs, 8'hFF);
		end
		$display("test event_masks done");
		meas(8'h00, 2'b00, 1'b0, 9'h0AB);
		meas(8'h03, 2'b00, 1'b0, 9'h123);
		meas(8'h01, 2'b11, 1'b1, 9'h1CE);
		meas(8'h00, 2'b11, 1'b0, 9'h0AB);
		meas(8'h00, 2'b10, 1'b0, 9'h1CE);
		$display("test measurement done");
		finish_test();
	end
endmodule // rimx_top_bench
`default_nettype wire
